// >>> dhg_defs.svh
`ifndef DHG_DEFS_SVH
`define DHG_DEFS_SVH
// host port offsets (low 3 bits plus SA9 select the port)
`define DHG_STATUS_OFS 10'h1F7
`define DHG_DRVSEL_OFS 10'h1F6
`define DHG_ERRPORT_OFS 10'h1F1
`define DHG_DATA_OFS 10'h1F0
`define DHG_ALTSTAT_OFS 10'h3F6
`define DHG_DIGIN_OFS 10'h3F7
// error code location in the sector buffer
`define DHG_ERRCODE_ADDR 16'h27F9
// status bit positions
`define DHG_ST_ERR 0
`define DHG_ST_IDX 1
`define DHG_ST_ECC_CORRECTED_FLAG 2
`define DHG_ST_DRQ 3
`define DHG_ST_SC 4
`define DHG_ST_WF 5
`define DHG_ST_RDY 6
`define DHG_ST_BUSY 7
`define DHG_STATUS_RST 8'h00
// local address windows, top three address bits
`define DHG_WIN_ROM 3'h0
`define DHG_WIN_COMP 3'h2
`define DHG_WIN_UCMD 3'h4
`define DHG_WIN_BUSYCLR 3'h5
`define DHG_WIN_DRQCLR 3'h6
`define DHG_WIN_DRQSET 3'h7
// local command register bits
`define DHG_UC_ERR 0
`define DHG_UC_ECC_CORRECTED_FLAG 1
`define DHG_UC_DMARD 4
`define DHG_UC_SDRQ_N 5
`define DHG_UC_SETINT 6
`define DHG_UC_SBUSY 7
// clock figures
`define DHG_OSC_MHZ 30
`define DHG_DIV_MFM 3
`define DHG_DIV_RLL 2
`endif

// >>> dhg_pkg.sv
package dhg_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic ale;
    logic [9:0] addr;
    logic sel;
  } dhg_host_bus_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic ale;
    logic [7:0] addr_hi;
  } dhg_local_bus_t;
  typedef struct packed {
    logic index;
    logic seek_done;
    logic ready;
    logic write_fault;
  } dhg_drive_t;
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_ACK = 3'b010,
    DMA_DONE = 3'b100
  } dhg_dma_state_t;
endpackage : dhg_pkg

// >>> dhg_fifo.sv
`timescale 1ns/1ns
module dhg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dhg_fifo_state_t;
  dhg_fifo_state_t st_ff;
  dhg_fifo_state_t nxt_st;
  logic push;
  logic pop;
  assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : dhg_fifo

// >>> dhg_top.sv
`timescale 1ns/1ns
`include "dhg_defs.svh"
// How it works
// - status readable always; all bits shown while busy
// - status read clears host interrupt
// - error flag from local command bit
// - index follows drive, gated by ready
// - corrected flag from local command bit
// - data request flag set and cleared by local writes
// - seek flag mirrors drive seek done
// - write fault flag mirrors drive input
// - ready flag mirrors drive ready input
// - drive select strobe on port write
// - digital input strobe on port read
// - iocs16 and wide flag on data port
// - local clock divided from core clock
// - encoding select: high MFM, low RLL
// - program rom enable in lowest window
// - request answered by low acknowledge
// - command attention on host command write
// - bus reset clears status, drives reset out
// - buffer byte strobes and transceiver controls
// - set-interrupt rising edge raises host irq
module dhg_top import dhg_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic oscillator_input_i,
  input wire dhg_host_bus_t host_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic host_irq_o,
  output logic iocs16_o,
  output logic wide_transfer_flag_o,
  output logic drive_select_write_strobe_o,
  output logic digital_input_read_strobe_o,
  input wire dhg_drive_t drive_i,
  input wire logic mfm_select_i,
  output logic mfm_mode_o,
  input wire dhg_local_bus_t local_i,
  input wire logic [7:0] local_wdata_i,
  output logic [7:0] local_rdata_o,
  output logic command_attention_o,
  output logic companion_chip_select_o,
  output logic companion_rw_direction_o,
  output logic program_rom_enable_o,
  input wire logic buffer_dma_request_i,
  output logic dma_ack_n_o,
  output logic local_sync_clock_o,
  output logic ext_reset_o,
  output logic buffer_write_upper_n_o,
  output logic buffer_read_upper_n_o,
  output logic buffer_write_lower_n_o,
  output logic buffer_read_lower_n_o,
  output logic low_transceiver_enable_n_o,
  output logic high_transceiver_enable_n_o,
  output logic transceiver_direction_o,
  output logic [7:0] fifo_data_o,
  output logic fifo_valid_o,
  input wire logic fifo_ready_i,
  output logic host_write_ready_o
);
  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [7:0] ucmd;
    logic data_request_flag;
    logic busy;
    logic irq;
    logic setint_prev;
    logic cmd_att;
    logic [7:0] rdata;
    logic [7:0] lrdata;
    logic drvsel_stb;
    logic digin_stb;
    dhg_dma_state_t dma;
    logic [1:0] div_cnt;
    logic div_clk;
    logic mfm;
    logic ext_rst;
  } dhg_state_t;
  dhg_state_t st_ff;
  dhg_state_t nxt_st;
  // ******************************
  // decode
  // ******************************
  function automatic logic port_hit(input logic [9:0] a, input logic [9:0] ofs);
    // primary and secondary windows differ only in bit 7
    port_hit = (a[9] == ofs[9]) && (a[2:0] == ofs[2:0]);
  endfunction : port_hit
  logic [7:0] status;
  logic host_rd_status;
  logic host_wr_cmd;
  logic host_data_acc;
  logic host_data_wr;
  logic [2:0] lwin;
  logic lacc;
  logic fifo_in_ready;
  assign lwin = local_i.addr_hi[7:5];
  assign lacc = local_i.rd || local_i.wr;
  assign host_rd_status = host_i.sel && host_i.rd && port_hit(host_i.addr, `DHG_STATUS_OFS);
  assign host_wr_cmd = host_i.sel && host_i.wr && port_hit(host_i.addr, `DHG_STATUS_OFS);
  assign host_data_acc = host_i.sel && port_hit(host_i.addr, `DHG_DATA_OFS);
  assign host_data_wr = host_data_acc && host_i.wr;
  always_comb begin
    status = `DHG_STATUS_RST;
    status[`DHG_ST_BUSY] = st_ff.busy;
    status[`DHG_ST_RDY] = drive_i.ready;
    status[`DHG_ST_WF] = drive_i.write_fault;
    status[`DHG_ST_SC] = drive_i.seek_done;
    status[`DHG_ST_DRQ] = st_ff.data_request_flag;
    status[`DHG_ST_ECC_CORRECTED_FLAG] = st_ff.ucmd[`DHG_UC_ECC_CORRECTED_FLAG];
    status[`DHG_ST_IDX] = drive_i.index && drive_i.ready;
    status[`DHG_ST_ERR] = st_ff.ucmd[`DHG_UC_ERR];
  end
  // ******************************
  // next state
  // ******************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.drvsel_stb = host_i.sel && host_i.wr && port_hit(host_i.addr, `DHG_DRVSEL_OFS);
    nxt_st.digin_stb = host_i.sel && host_i.rd && port_hit(host_i.addr, `DHG_DIGIN_OFS);
    if (host_i.sel && host_i.rd &&
        (port_hit(host_i.addr, `DHG_STATUS_OFS) || port_hit(host_i.addr, `DHG_ALTSTAT_OFS))) begin
      nxt_st.rdata = status;
    end
    if (host_rd_status) begin
      nxt_st.irq = 1'b0;
    end
    if (host_wr_cmd) begin
      nxt_st.cmd_att = 1'b1;
      nxt_st.busy = 1'b1;
    end
    // local command register and strobe ports
    if (local_i.wr && lwin == `DHG_WIN_UCMD) begin
      nxt_st.ucmd = local_wdata_i;
      nxt_st.cmd_att = 1'b0;
      if (local_wdata_i[`DHG_UC_SBUSY]) begin
        nxt_st.busy = 1'b1;
      end
      if (!local_wdata_i[`DHG_UC_SDRQ_N]) begin
        nxt_st.data_request_flag = 1'b1;
      end
    end
    // a host command in the same cycle keeps busy set
    if (local_i.wr && lwin == `DHG_WIN_BUSYCLR && !st_ff.ucmd[`DHG_UC_SBUSY] && !host_wr_cmd) begin
      nxt_st.busy = 1'b0;
    end
    if (local_i.wr && lwin == `DHG_WIN_DRQCLR) begin
      nxt_st.data_request_flag = 1'b0;
      nxt_st.irq = 1'b0;
    end
    if (local_i.wr && lwin == `DHG_WIN_DRQSET) begin
      nxt_st.data_request_flag = 1'b1;
    end
    nxt_st.setint_prev = st_ff.ucmd[`DHG_UC_SETINT];
    // set wins over a same-cycle status read clear
    if (st_ff.ucmd[`DHG_UC_SETINT] && !st_ff.setint_prev) begin
      nxt_st.irq = 1'b1;
    end
    if (local_i.rd) begin
      nxt_st.lrdata = status;
    end
    // dma handshake, one byte per request
    case (st_ff.dma)
      DMA_IDLE: begin
        // a request is only acknowledged when a byte is waiting to be handed over
        if (buffer_dma_request_i && fifo_valid_o) begin
          nxt_st.dma = DMA_ACK;
        end
      end
      DMA_ACK: begin
        nxt_st.dma = DMA_DONE;
      end
      DMA_DONE: begin
        if (!buffer_dma_request_i) begin
          nxt_st.dma = DMA_IDLE;
        end
      end
      default: begin
        nxt_st.dma = DMA_IDLE;
      end
    endcase
    // local clock: /3 gives 10 MHz for MFM, /2 gives 15 MHz for RLL
    nxt_st.mfm = mfm_select_i;
    if (st_ff.div_cnt >= 2'(st_ff.mfm ? `DHG_DIV_MFM - 1 : `DHG_DIV_RLL - 1)) begin
      nxt_st.div_cnt = 2'h0;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
    end
    nxt_st.div_clk = (nxt_st.div_cnt == 2'h0);
    nxt_st.ext_rst = 1'b0;
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
      st_ff.dma <= DMA_IDLE;
      st_ff.ext_rst <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // oscillator input is not used; the divider counts core clock cycles instead
  logic osc_unused;
  assign osc_unused = oscillator_input_i;
  // ******************************
  // buffer path
  // ******************************
  dhg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(host_data_wr),
    .in_ready_o(fifo_in_ready),
    .in_data_i(host_wdata_i),
    .out_valid_o(fifo_valid_o),
    .out_ready_i(fifo_ready_i && st_ff.dma == DMA_ACK),
    .out_data_o(fifo_data_o)
  );
  // ******************************
  // outputs
  // ******************************
  assign host_write_ready_o = fifo_in_ready;
  assign host_rdata_o = st_ff.rdata;
  assign host_irq_o = st_ff.irq;
  assign iocs16_o = host_data_acc;
  assign wide_transfer_flag_o = host_data_acc;
  assign drive_select_write_strobe_o = st_ff.drvsel_stb;
  assign digital_input_read_strobe_o = st_ff.digin_stb;
  assign mfm_mode_o = st_ff.mfm;
  assign local_rdata_o = st_ff.lrdata;
  assign command_attention_o = st_ff.cmd_att;
  assign companion_chip_select_o = lacc && lwin == `DHG_WIN_COMP;
  assign companion_rw_direction_o = local_i.wr;
  assign program_rom_enable_o = lacc && lwin == `DHG_WIN_ROM;
  assign dma_ack_n_o = !(st_ff.dma == DMA_ACK);
  assign local_sync_clock_o = st_ff.div_clk;
  assign ext_reset_o = st_ff.ext_rst;
  // host data port byte split over the two buffer halves
  assign buffer_write_upper_n_o = !(host_data_wr);
  assign buffer_write_lower_n_o = !(host_data_wr || (st_ff.dma == DMA_ACK && st_ff.ucmd[`DHG_UC_DMARD]));
  assign buffer_read_upper_n_o = !(host_data_acc && host_i.rd);
  assign buffer_read_lower_n_o = !((host_data_acc && host_i.rd) ||
                                   (st_ff.dma == DMA_ACK && !st_ff.ucmd[`DHG_UC_DMARD]));
  assign low_transceiver_enable_n_o = !host_data_acc;
  assign high_transceiver_enable_n_o = !host_data_acc;
  assign transceiver_direction_o = host_i.rd;
endmodule : dhg_top

// >>> dhg_monitor.sv
`timescale 1ns/1ns
module dhg_monitor import dhg_pkg::*; (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire dhg_host_bus_t host_i,
  input wire dhg_local_bus_t local_i,
  input wire logic iocs16_o,
  input wire logic drive_select_write_strobe_o,
  input wire logic digital_input_read_strobe_o,
  input wire logic companion_rw_direction_o,
  input wire logic buffer_dma_request_i,
  input wire logic dma_ack_n_o,
  input wire logic local_sync_clock_o,
  input wire logic ext_reset_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ****
  // host strobes and dma handshake
  // ****
  sequence s_sel_wr;
    host_i.sel && host_i.wr && host_i.addr == 10'h1F6;
  endsequence
  sequence s_din_rd;
    host_i.sel && host_i.rd && host_i.addr == 10'h3F7;
  endsequence
  sequence s_ack_given;
    buffer_dma_request_i ##1 !dma_ack_n_o;
  endsequence
  a_drvsel_strobe: assert property (s_sel_wr |=> drive_select_write_strobe_o)
    else $error("no drive select strobe");
  a_digin_strobe: assert property (s_din_rd |=> digital_input_read_strobe_o)
    else $error("no digital input strobe");
  a_ack_one_cycle: assert property (s_ack_given |=> dma_ack_n_o)
    else $error("acknowledge too long");
  a_ack_cause: assert property ($fell(dma_ack_n_o) |-> $past(buffer_dma_request_i))
    else $error("acknowledge without request");
  a_wide_window: assert property (iocs16_o |-> host_i.addr[2:0] == 3'h0 && !host_i.addr[9])
    else $error("iocs16 outside data port");
  a_dir_follow: assert property (companion_rw_direction_o == local_i.wr)
    else $error("companion direction wrong");
  a_reset_out: assert property ($fell(reset_i) |-> ##[1:2] !ext_reset_o)
    else $error("reset output stuck");
  a_sync_clock: assert property (1'b1 |-> ##[1:3] $changed(local_sync_clock_o))
    else $error("local clock stalled");
endmodule : dhg_monitor
bind dhg_top dhg_monitor u_mon (.core_clk_i, .reset_i, .host_i, .local_i, .iocs16_o, .drive_select_write_strobe_o,
  .digital_input_read_strobe_o, .companion_rw_direction_o, .buffer_dma_request_i, .dma_ack_n_o,
  .local_sync_clock_o, .ext_reset_o);

// >>> dhg_far_model.sv
`timescale 1ns/1ns
module dhg_far_model (
  input wire logic core_clk_i,
  input wire logic enable_i,
  input wire logic ack_n_i,
  output logic req_o,
  output logic ready_o
);
  int seed = 38612;
  int n;
  initial begin
    req_o = 1'b0;
    ready_o = 1'b0;
    forever begin
      @(negedge core_clk_i);
      ready_o = enable_i;
      if (enable_i) begin
        req_o = 1'b1;
        n = 0;
        // bounded so a silent design cannot hang the run
        do begin
          @(negedge core_clk_i);
          n++;
        end while (ack_n_i !== 1'b0 && n < 40);
        @(negedge core_clk_i);
        req_o = 1'b0;
        ready_o = 1'b0;
        // idle gap stalls the drain like a slow partner
        repeat (2'($random(seed))) @(negedge core_clk_i);
      end
    end
  end
endmodule : dhg_far_model

// >>> dhg_testbench.sv
`timescale 1ns/1ns
module testbench import dhg_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mfm = 1'b1;
  logic en = 1'b0;
  logic fr, req, irq, iocs, dsel, dinr, mfmo, catt, csel, rom, ack, sclk, xrst, fv, hwr, sp, wide;
  dhg_host_bus_t hb = '0;
  dhg_local_bus_t lb = '0;
  dhg_drive_t drv = '0;
  logic [7:0] hwd = 8'h00;
  logic [7:0] lwd = 8'h00;
  logic [7:0] hrd, fd, d;
  logic [7:0] q[$];
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 38612;
  int tog;
  initial forever #50 clk = ~clk;
  dhg_top #(.FIFO_DEPTH(4)) dut (.core_clk_i(clk), .reset_i(rst), .oscillator_input_i(1'b0), .host_i(hb),
    .host_wdata_i(hwd), .host_rdata_o(hrd), .host_irq_o(irq), .iocs16_o(iocs), .wide_transfer_flag_o(wide),
    .drive_select_write_strobe_o(dsel), .digital_input_read_strobe_o(dinr), .drive_i(drv), .mfm_select_i(mfm),
    .mfm_mode_o(mfmo), .local_i(lb), .local_wdata_i(lwd), .local_rdata_o(), .command_attention_o(catt),
    .companion_chip_select_o(csel), .companion_rw_direction_o(), .program_rom_enable_o(rom),
    .buffer_dma_request_i(req), .dma_ack_n_o(ack), .local_sync_clock_o(sclk), .ext_reset_o(xrst),
    .buffer_write_upper_n_o(), .buffer_read_upper_n_o(), .buffer_write_lower_n_o(), .buffer_read_lower_n_o(),
    .low_transceiver_enable_n_o(), .high_transceiver_enable_n_o(), .transceiver_direction_o(),
    .fifo_data_o(fd), .fifo_valid_o(fv), .fifo_ready_i(fr), .host_write_ready_o(hwr));
  dhg_far_model far (.core_clk_i(clk), .enable_i(en), .ack_n_i(ack), .req_o(req), .ready_o(fr));
  // ****
  // checking and bus tasks
  // ****
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  function automatic logic [7:0] st(input logic r, input logic c, input logic e);
    return {1'b0, drv.ready, drv.write_fault, drv.seek_done, r, c, drv.index & drv.ready, e};
  endfunction : st
  task automatic hop(input logic w, input logic [9:0] a, input logic [7:0] v);
    hb.ale = 1'b1;
    hb.addr = a;
    @(negedge clk);
    hb = '{rd: !w, wr: w, ale: 1'b0, addr: a, sel: 1'b1};
    hwd = v;
    #1 chk("iocs16", iocs, a == 10'h1F0);
    chk("wide transfer", wide, a == 10'h1F0);
    @(negedge clk);
    hb = '{rd: 1'b0, wr: 1'b0, ale: 1'b0, addr: a, sel: 1'b0};
  endtask : hop
  task automatic lop(input logic [2:0] win, input logic [7:0] v);
    lb.ale = 1'b1;
    lb.addr_hi = {win, 5'($random(seed))};
    @(negedge clk);
    lb = '{rd: win < 3'h4, wr: win > 3'h3, ale: 1'b0, addr_hi: lb.addr_hi};
    lwd = v;
    #1 chk("rom enable", rom, win == 3'h0);
    chk("companion select", csel, win == 3'h2);
    @(negedge clk);
    lb = '{rd: 1'b0, wr: 1'b0, ale: 1'b0, addr_hi: lb.addr_hi};
  endtask : lop
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!ack && fv && fr) chk("dma data", fd, q.size() ? q.pop_front() : 8'hXX);
    if (cycles == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk("ext reset", xrst, 1'b1);
    for (int i = 0; i < 4; i++) lop(3'(i), 8'h00);
    repeat (8) begin
      drv = 4'($random(seed));
      mfm = 1'($random(seed));
      repeat (3) @(negedge clk);
      hop(1'b0, 10'h1F7, 8'h00);
      chk("status", hrd, st(0, 0, 0));
      chk("mfm", mfmo, mfm);
      tog = 0;
      repeat (12) begin
        sp = sclk;
        @(negedge clk);
        tog += (sclk !== sp);
      end
      chk("sync clock", 8'(tog), mfm ? 8'h08 : 8'h0C);
    end
    lop(3'h4, 8'h23);
    hop(1'b0, 10'h1F7, 8'h00);
    chk("status", hrd, st(0, 1, 1));
    lop(3'h4, 8'h60);
    repeat (3) @(negedge clk);
    chk("host irq", irq, 1'b1);
    hop(1'b0, 10'h1F7, 8'h00);
    chk("host irq", irq, 1'b0);
    lop(3'h7, 8'h00);
    hop(1'b0, 10'h3F6, 8'h00);
    chk("status", hrd, st(1, 0, 0));
    lop(3'h6, 8'h00);
    hop(1'b1, 10'h1F7, 8'h20);
    chk("attention", catt, 1'b1);
    hop(1'b0, 10'h1F7, 8'h00);
    chk("busy", hrd[7], 1'b1);
    lop(3'h4, 8'h20);
    chk("attention", catt, 1'b0);
    lop(3'h5, 8'h00);
    hop(1'b0, 10'h1F7, 8'h00);
    chk("status", hrd, st(0, 0, 0));
    for (int i = 0; i < 2; i++) begin
      hop(1'b1, i ? 10'h176 : 10'h1F6, 8'h00);
      chk("drive select", dsel, 1'b1);
      hop(1'b0, i ? 10'h377 : 10'h3F7, 8'h00);
      chk("digital input", dinr, 1'b1);
    end
    repeat (4) begin
      d = 8'($random(seed));
      q.push_back(d);
      hop(1'b1, 10'h1F0, d);
    end
    chk("write ready", hwr, 1'b0);
    hop(1'b1, 10'h1F0, 8'hA5);
    en = 1'b1;
    repeat (60) @(negedge clk);
    en = 1'b0;
    chk("left over", 8'(q.size()), 8'h00);
    chk("fifo valid", fv, 1'b0);
    repeat (4) @(negedge clk);
    lop(3'h4, 8'hE0);
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("ext reset", xrst, 1'b1);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("host irq", irq, 1'b0);
    hop(1'b0, 10'h1F7, 8'h00);
    chk("status", hrd, st(0, 0, 0));
    finish_test;
  end
endmodule : testbench
